// ==== rprom_defs.vh ====
// Constants for the registered PROM read path
`ifndef RPROM_DEFS_VH
`define RPROM_DEFS_VH
`define RPROM_ADDR_W 11
`define RPROM_DATA_W 8
`define RPROM_DEPTH 2048
`define RPROM_INIT_CLEAR 8'h00
`define RPROM_INIT_PRESET 8'hFF
`define RPROM_SET_STATE 8'hFF
`endif

// ==== rprom_read_path.v ====
// Registered PROM read path: ROM array, master/slave output register, enable and preload
`include "rprom_defs.vh"

module rprom_read_path #(
    parameter ADDR_W = `RPROM_ADDR_W,
    parameter DATA_W = `RPROM_DATA_W,
    parameter DEPTH = `RPROM_DEPTH,
    parameter SYNC_ENABLE = 1,
    parameter SYNC_PRELOAD = 0,
    parameter [DATA_W-1:0] PRELOAD_WORD = `RPROM_INIT_CLEAR
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [ADDR_W-1:0] word_address,
    input wire enable,
    input wire preload_n,
    output reg [DATA_W-1:0] registered_data_out,
    output reg [DATA_W-1:0] data_out_pins,
    output reg data_out_oe
);

    // Structure: array read, master select, slave input, drive state, then output flops.
    // Every output is a flop, so pin-level enable and preload act at the next enabled edge.
    // Limitation: an asynchronous enable or preload therefore lags its pin by one clock;
    // a system that needs the immediate float must gate the pins outside this block.

    // Build-time variant choices; no pin can change them while the part is in service
    localparam ENABLE_IS_SYNC = (SYNC_ENABLE != 0);
    localparam PRELOAD_IS_SYNC = (SYNC_PRELOAD != 0);

    // Value held by the register after power-up
    // A set register reads as all ones
    localparam [DATA_W-1:0] SET_WORD = `RPROM_SET_STATE;

    // Binary codes of the drive state
    localparam [0:0] DRV_FLOAT = 1'h0;
    localparam [0:0] DRV_ON = 1'h1;

    // Read-only contents; no write port exists, so the array is fixed after elaboration
    reg [DATA_W-1:0] rom [0:DEPTH-1];
    // Loop index for the elaboration-time fill
    integer i;

    // Master stage and slave input
    wire [DATA_W-1:0] array_word;
    wire [DATA_W-1:0] master;
    reg [DATA_W-1:0] next_slave;

    // Preload decode
    reg preload_active;
    reg preload_hits_slave;

    // Drive control
    reg drive_state;
    reg next_drive_state;
    reg reset_drive;

    // Default contents: each word holds the low bits of its own address,
    // so a checker can predict any read without a second copy of the array
    function [DATA_W-1:0] default_word;
        input integer index;
        begin
            default_word = index[DATA_W-1:0];
        end
    endfunction

    // The contents stand in for programmed fuses; replace this block to load real microcode
    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            rom[i] = default_word(i);
        end
    end

    // Array read; the master follows the address with no clock, as the sense path does
    assign array_word = rom[word_address];

    // Preload decode: an asynchronous preload also reaches the slave directly
    // If preload and a new address arrive together, the preload wins
    always @* begin
        preload_active = 1'h0;
        preload_hits_slave = 1'h0;
        if (!preload_n) begin
            preload_active = 1'h1;
            if (PRELOAD_IS_SYNC) begin
                preload_hits_slave = 1'h0;
            end else begin
                preload_hits_slave = 1'h1;
            end
        end
    end

    // Master stage, bit by bit: the preload word replaces the array word while preload is low
    // Selecting per bit passes a partly programmed preload word through unchanged
    genvar b;
    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_master_bit
            assign master[b] = preload_active ? PRELOAD_WORD[b] : array_word[b];
        end
    endgenerate

    // Slave input. With one clock an asynchronous preload cannot act between edges, so it
    // lands at the next enabled edge, the same edge that a synchronous preload uses
    always @* begin
        case (preload_hits_slave)
            1'h1: begin
                next_slave = PRELOAD_WORD;
            end
            default: begin
                next_slave = master;
            end
        endcase
    end

    // Drive state. Both enable styles are sampled at the enabled edge: the pins must leave a
    // flop, so the asynchronous style lags its pin by one clock in this model.
    // The synchronous style keeps its state until an edge samples the other level.
    always @* begin
        if (ENABLE_IS_SYNC) begin
            case (drive_state)
                DRV_FLOAT: begin
                    if (!enable) begin
                        next_drive_state = DRV_ON;
                    end else begin
                        next_drive_state = DRV_FLOAT;
                    end
                end
                DRV_ON: begin
                    if (enable) begin
                        next_drive_state = DRV_FLOAT;
                    end else begin
                        next_drive_state = DRV_ON;
                    end
                end
                default: begin
                    next_drive_state = DRV_FLOAT;
                end
            endcase
        end else begin
            // Asynchronous style: the enable level alone decides, whatever the state was;
            // a high enable floats the pins at the next enabled edge rather than at once
            if (enable) begin
                next_drive_state = DRV_FLOAT;
            end else begin
                next_drive_state = DRV_ON;
            end
        end
    end

    // Power-up drive: the synchronous style always starts floating, the asynchronous one
    // floats only while its enable is high
    always @* begin
        if (ENABLE_IS_SYNC) begin
            reset_drive = DRV_FLOAT;
        end else begin
            reset_drive = !enable;
        end
    end

    // Clock enable low freezes all state; reset still acts so a stalled system can restart
    // Drive state
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            drive_state <= reset_drive;
        end else if (clk_en) begin
            drive_state <= next_drive_state;
        end else begin
            drive_state <= drive_state;
        end
    end

    // Slave stage; between enabled edges it holds whatever the address and enable do
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            registered_data_out <= SET_WORD;
        end else if (clk_en) begin
            registered_data_out <= next_slave;
        end else begin
            registered_data_out <= registered_data_out;
        end
    end

    // Pin value: a second copy of the slave, so the pins too come straight from a flop;
    // while floating it still tracks the slave, so a later enable shows the held word at once
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            data_out_pins <= SET_WORD;
        end else if (clk_en) begin
            data_out_pins <= next_slave;
        end else begin
            data_out_pins <= data_out_pins;
        end
    end

    // Pin drive enable, high while the pins are driven
    // Held low through reset in the synchronous style
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            data_out_oe <= reset_drive;
        end else if (clk_en) begin
            data_out_oe <= next_drive_state;
        end else begin
            data_out_oe <= data_out_oe;
        end
    end

endmodule // rprom_read_path

// ==== rprom_read_path_asserts.sv ====
// Checker for the registered PROM read path
module rprom_read_path_asserts(input wire ref_clk, input wire sys_rst, input wire clk_en,
    input wire [10:0] word_address, input wire enable, input wire preload_n,
    input wire [7:0] registered_data_out, input wire [7:0] data_out_pins, input wire data_out_oe);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_READ: assert property (clk_en && !enable && preload_n |=>
        registered_data_out == $past(word_address[7:0])) else $error("read word wrong");
    AST_FLOAT: assert property (clk_en && enable |=> !data_out_oe) else $error("no float");
    AST_DRIVE: assert property (clk_en && !enable |=> data_out_oe) else $error("no drive");
    AST_HOLD: assert property (!clk_en |=> $stable(registered_data_out)) else $error("moved");
    AST_STILL: assert property (!clk_en [*2] |-> $stable(data_out_oe)) else $error("oe moved");
    AST_PRE: assert property (clk_en && !preload_n |=> registered_data_out == 8'h00) else $error("pre");
    AST_PINS: assert property (data_out_pins == registered_data_out) else $error("pins differ");
    AST_PWR: assert property (disable iff (1'b0) sys_rst && clk_en |=>
        registered_data_out == 8'hFF && !data_out_oe) else $error("reset state wrong");
    cover property (!preload_n);
    cover property (enable ##1 !enable);
    cover property (!clk_en);
endmodule // rprom_read_path_asserts
bind rprom_read_path rprom_read_path_asserts rprom_read_path_asserts_inst(.ref_clk, .sys_rst,
    .clk_en, .word_address, .enable, .preload_n, .registered_data_out, .data_out_pins, .data_out_oe);

// ==== rprom_seq.sv ====
// Sequencer model presenting address, enable and preload to the PROM
module rprom_seq(input wire ref_clk, input wire [10:0] a_req, input wire e_req, input wire p_req,
    output logic [10:0] word_address, output logic enable, output logic preload_n);
    timeunit 1ns; timeprecision 1ps;
    always @(posedge ref_clk) #1 {word_address, enable, preload_n} <= {a_req, e_req, p_req};
endmodule // rprom_seq

// ==== registered_prom_read_path_tb.sv ====
// Testbench for the registered PROM read path
module registered_prom_read_path_tb;
    timeunit 1ns; timeprecision 1ps;
    logic ref_clk = 0, sys_rst = 1, clk_en = 1, e_req = 0, p_req = 1, enable, preload_n, data_out_oe;
    logic [10:0] a_req = 0, word_address;
    logic [7:0] registered_data_out, data_out_pins;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [21:0] rows [3] = '{{11'h7FF, 2'h1, 9'h1FF}, {11'h123, 2'h1, 9'h123}, {11'h0AA, 2'h0, 9'h100}};
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 200) begin n_mismatch++; test_done; end
    rprom_seq rprom_seq_inst(.ref_clk, .a_req, .e_req, .p_req, .word_address, .enable, .preload_n);
    rprom_read_path rprom_read_path_inst(.ref_clk, .sys_rst, .clk_en, .word_address, .enable,
        .preload_n, .registered_data_out, .data_out_pins, .data_out_oe);
    task chk(logic [8:0] s, logic [8:0] x); n_compared++;
        if (s !== x) begin n_mismatch++; $display("Error t=%0t seen %h exp %h", $time, s, x); end
    endtask
    task step(int n); repeat (n) @(posedge ref_clk); #1; endtask
    task test_done; $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        step(3); chk({data_out_oe, registered_data_out}, 9'h0FF);
        $display("reset test done");
        sys_rst = 0;
        foreach (rows[i]) begin {a_req, e_req, p_req} = rows[i][21:9]; step(2);
            chk({data_out_oe, registered_data_out}, rows[i][8:0]); $display("row %0d done", i); end
        e_req = 1; step(2); chk({data_out_oe, registered_data_out}, 9'h000);
        {e_req, p_req, clk_en} = 3'h2; step(3); chk({data_out_oe, registered_data_out}, 9'h000);
        clk_en = 1; step(1); chk({data_out_oe, registered_data_out}, 9'h1AA);
        sys_rst = 1; step(1); chk({data_out_oe, registered_data_out}, 9'h0FF);
        sys_rst = 0; step(1); chk({data_out_oe, data_out_pins}, 9'h1AA);
        $display("mid-run reset test done");
        $display("hand tests done"); test_done;
    end
endmodule // registered_prom_read_path_tb
